// ===== rfsme_pkg.sv
// Constants shared by the step modulation encoder and its coarse lookup ROM.
// Assumes one sample clock; all widths and counts are fixed by the amplifier array.
package rfsme_pkg;

    // Sample word layout; bit 1 of the printed numbering is index 11 here
    localparam int SAMPLE_W = 12;
    localparam int COARSE_W = 7;
    localparam int FINE_W = 5;
    localparam int COARSE_MSB_POS = 11;
    localparam int COARSE_LSB_POS = 5;
    localparam int FINE_MSB_POS = 4;
    localparam int FINE_LSB_POS = 0;

    // Amplifier array
    localparam int COARSE_AMPS = 123;
    localparam int TOTAL_AMPS = 128;
    localparam int ROM_DEPTH = 128;

    // Amplitude expressed in 1/32 of a coarse step
    localparam int FRAC_PER_STEP = 32;
    localparam int AMPL_W = 12;
    localparam int COUNT_W = 7;

    // Reference levels of the sample source
    localparam logic [COARSE_W-1:0] CARRIER_STEPS = 7'h2f;
    localparam logic [COARSE_W-1:0] PEAK_STEPS = 7'h5e;
    localparam logic [COARSE_W-1:0] MAX_STEPS = 7'h7b;
    localparam logic [FINE_W-1:0] FINE_ALL_ON = 5'h1f;

    // Reset values of the enables: every amplifier off
    localparam logic [COARSE_AMPS-1:0] COARSE_RESET = '0;
    localparam logic [FINE_W-1:0] FINE_RESET = 5'h00;

endpackage : rfsme_pkg

// ===== rfsme_coarse_rom.sv
// Coarse lookup ROM: seven-bit step count in, thermometer enable word out.
// Assumes a purely combinational read; the caller registers the data.
`timescale 1ns/1ns
module rfsme_coarse_rom
    import rfsme_pkg::*;
#(
    parameter int DEPTH = ROM_DEPTH,
    parameter int WIDTH = COARSE_AMPS
)
(
    input wire logic [COARSE_W-1:0] addr_i, // Coarse field
    output logic [WIDTH-1:0] data_o // Coarse enables, bit 0 first
);

    wire [WIDTH-1:0] rom_mem [0:DEPTH-1];

    // Each entry turns on as many amplifiers as its address, capped at WIDTH
    for (genvar a = 0; a < DEPTH; a++)
    begin : g_entry
        localparam int SAT = (a > WIDTH) ? WIDTH : a;
        for (genvar b = 0; b < WIDTH; b++)
        begin : g_bit
            assign rom_mem[a][b] = (b < SAT) ? 1'b1 : 1'b0;
        end
    end

    // Asynchronous read
    assign data_o = rom_mem[addr_i];

endmodule : rfsme_coarse_rom

// ===== rfsme_encoder.sv
// Step modulation encoder: turns each 12-bit sample into 128 amplifier enables.
// Assumes sample_i and sample_valid_i come from logic on mclk_i; one strobe per sample.
`timescale 1ns/1ns

module rfsme_encoder
    import rfsme_pkg::*;
(
    input wire logic mclk_i, // Sample clock, 100 MHz
    input wire logic rst_i, // Asynchronous reset, active high
    input wire logic ce_i, // Clock enable, freezes all state when low
    input wire logic [SAMPLE_W-1:0] sample_i, // Converter sample word
    input wire logic sample_valid_i, // One-cycle strobe per new sample
    output logic [COARSE_AMPS-1:0] coarse_en_o, // Equal-voltage amplifier enables
    output logic [FINE_W-1:0] fine_en_o, // Binary-weighted enables, bit 4 = half step
    output logic [COUNT_W-1:0] coarse_count_o, // Coarse amplifiers now on
    output logic [AMPL_W-1:0] amplitude_o // Output level in 1/32 steps
);

    logic [COARSE_W-1:0] coarse_field;
    logic [FINE_W-1:0] fine_field;
    logic [COARSE_AMPS-1:0] rom_data;
    logic [COUNT_W-1:0] next_count;
    logic [SAMPLE_W-1:0] last_sample;
    logic take;

    // Field split; sample bit 1 sits at the top index
    assign coarse_field = sample_i[COARSE_MSB_POS:COARSE_LSB_POS];
    assign fine_field = sample_i[FINE_MSB_POS:FINE_LSB_POS];
    // Clock enable gates the take, so a low enable drops the strobe too
    assign take = ce_i && sample_valid_i;

    // Thermometer table; saturation above 123 lives in the table itself
    // A table instead of a count-to-thermometer decoder keeps the enable
    // pattern a pure lookup, so every entry can be judged on its own
    rfsme_coarse_rom #(
        .DEPTH(ROM_DEPTH),
        .WIDTH(COARSE_AMPS)
    ) u_rom (
        .addr_i(coarse_field),
        .data_o(rom_data)
    );

    // Count that the ROM word represents, kept alongside for status
    // Derived from the field, not from the ROM word, so the two paths
    // cross-check each other in the assertions below
    assign next_count = (coarse_field > MAX_STEPS) ? MAX_STEPS : coarse_field;

    // Coarse enables; registered so the combiner never sees a ROM glitch
    // Limitation: a sample offered during reset is lost, not replayed after release
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            coarse_en_o <= COARSE_RESET;
        else if (take)
            coarse_en_o <= rom_data;
    end

    // Fine enables share the same edge as the coarse ones
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            fine_en_o <= FINE_RESET;
        else if (take)
            fine_en_o <= fine_field;
    end

    // Coarse count status
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            coarse_count_o <= '0;
        else if (take)
            coarse_count_o <= next_count;
    end

    // Amplitude in 1/32 steps: fine bits add 16,8,4,2,1, at most 31 of 32
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            amplitude_o <= '0;
        else if (take)
            amplitude_o <= {next_count, fine_field};
    end

    // Last accepted sample, used to judge step-to-step behaviour
    // Only the checks read it, so synthesis trims it away
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            last_sample <= '0;
        else if (take)
            last_sample <= sample_i;
    end

    // Checks on the encoder's outputs
    // Those triggered by take judge the registered outputs against the sample taken one edge
    // earlier; nothing here feeds back into the datapath
    logic [AMPL_W-1:0] fine_weight;
    always_comb
    begin
        fine_weight = '0;
        for (int i = 0; i < FINE_W; i++)
            if (fine_en_o[i])
                fine_weight = fine_weight + AMPL_W'(1 << i);
    end

    AST_FINE_SPLIT: assert property (@(posedge mclk_i) disable iff (rst_i)
        take |=> fine_en_o == $past(sample_i[FINE_MSB_POS:FINE_LSB_POS]))
        else $error("fine enables do not follow the low five sample bits");

    AST_COARSE_COUNT: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && (sample_i[COARSE_MSB_POS:COARSE_LSB_POS] <= MAX_STEPS) |=>
        ($countones(coarse_en_o) == int'($past(sample_i[COARSE_MSB_POS:COARSE_LSB_POS]))))
        else $error("coarse enable count differs from coarse field");

    AST_ROM_DRIVES: assert property (@(posedge mclk_i) disable iff (rst_i)
        take |=> coarse_en_o == $past(rom_data))
        else $error("coarse enables are not the ROM word");

    AST_FINE_WEIGHT: assert property (@(posedge mclk_i) disable iff (rst_i)
        amplitude_o == AMPL_W'($countones(coarse_en_o) * FRAC_PER_STEP) + fine_weight)
        else $error("amplitude does not match weighted enables");

    AST_FINE_FULL: assert property (@(posedge mclk_i) disable iff (rst_i)
        (fine_en_o == FINE_ALL_ON) |-> fine_weight == AMPL_W'(FRAC_PER_STEP - 1))
        else $error("all fine enables do not sum to 31/32");

    // Rollover from all fine bits set is the hazard point: a late coarse
    // enable would briefly drop the output by almost a whole step
    AST_ROLLOVER: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && last_sample[FINE_MSB_POS:FINE_LSB_POS] == FINE_ALL_ON
        && last_sample[COARSE_MSB_POS:COARSE_LSB_POS] < MAX_STEPS
        && sample_i == last_sample + 12'h001 && fine_en_o == FINE_ALL_ON
        |=> fine_en_o == FINE_RESET && coarse_count_o == $past(coarse_count_o) + 7'h01)
        else $error("fine rollover did not add one coarse step");

    AST_PEAK: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i[COARSE_MSB_POS:COARSE_LSB_POS] == PEAK_STEPS
        |=> $countones(coarse_en_o) == int'(PEAK_STEPS) && coarse_count_o == PEAK_STEPS)
        else $error("peak word did not turn on 94 coarse amplifiers");

    AST_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i == 12'h000 |=> coarse_en_o == COARSE_RESET && fine_en_o == FINE_RESET)
        else $error("zero sample left an amplifier on");

    AST_TRACK: assert property (@(posedge mclk_i) disable iff (rst_i)
        take ##1 take |=> last_sample == $past(sample_i) && coarse_en_o == $past(rom_data))
        else $error("back-to-back samples not both applied");

    AST_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        !take |=> $stable(coarse_en_o) && $stable(fine_en_o) && $stable(amplitude_o))
        else $error("enables changed without an accepted sample");

    AST_SATURATE: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i[COARSE_MSB_POS:COARSE_LSB_POS] > MAX_STEPS
        |=> (&coarse_en_o) && coarse_count_o == MAX_STEPS)
        else $error("coarse field above 123 did not saturate");

    // Thermometer shape: the carry out of the low ones must land on zeros
    logic coarse_is_thermo;
    assign coarse_is_thermo = ((coarse_en_o & (coarse_en_o + COARSE_AMPS'(1))) == '0);

    AST_THERMO: assert property (@(posedge mclk_i) disable iff (rst_i)
        coarse_is_thermo)
        else $error("coarse enables are not a thermometer from bit 0");

    AST_COUNT_MATCH: assert property (@(posedge mclk_i) disable iff (rst_i)
        $countones(coarse_en_o) == int'(coarse_count_o))
        else $error("coarse count status disagrees with the enables");

    AST_AMPL_FIELDS: assert property (@(posedge mclk_i) disable iff (rst_i)
        amplitude_o == {coarse_count_o, fine_en_o})
        else $error("amplitude status is not from the same sample as the enables");

    // A coarse field that repeats must not disturb the coarse amplifiers
    AST_FINE_ONLY: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i[COARSE_MSB_POS:COARSE_LSB_POS] == last_sample[COARSE_MSB_POS:COARSE_LSB_POS]
        |=> $stable(coarse_en_o))
        else $error("fine-only change moved a coarse enable");

    // Clock enable low freezes every register, status included
    AST_CE_FREEZE: assert property (@(posedge mclk_i) disable iff (rst_i)
        !ce_i |=> $stable(coarse_en_o) && $stable(fine_en_o) && $stable(coarse_count_o)
        && $stable(amplitude_o) && $stable(last_sample))
        else $error("state moved while the clock enable was low");

    // One check per fine amplifier; each bit has its own enable and no other
    for (genvar k = 0; k < FINE_W; k++)
    begin : g_fine_chk
        AST_FINE_BIT: assert property (@(posedge mclk_i) disable iff (rst_i)
            take |=> fine_en_o[k] == $past(sample_i[FINE_LSB_POS + k]))
            else $error("a fine enable does not follow its own sample bit");
    end

    AST_ZERO_STATUS: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i == 12'h000 |=> coarse_count_o == '0 && amplitude_o == '0)
        else $error("zero sample left a nonzero level in the status");

    // Main scenarios worth seeing in simulation
    CVR_CARRIER: cover property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i == {CARRIER_STEPS, FINE_RESET});

    CVR_ROLLOVER: cover property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i == {CARRIER_STEPS, FINE_ALL_ON}
        ##1 take && sample_i == {CARRIER_STEPS + 7'h01, FINE_RESET});

    CVR_PEAK: cover property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i == {PEAK_STEPS, FINE_RESET});

    CVR_SATURATE: cover property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i[COARSE_MSB_POS:COARSE_LSB_POS] == 7'h7f);

    CVR_ZERO: cover property (@(posedge mclk_i) disable iff (rst_i)
        take && sample_i == 12'h000);

endmodule : rfsme_encoder

// ===== rfsme_source_model.sv
// Upstream sample source model: presents one 12-bit word per strobe.
// Assumes every task is entered on a falling edge of the sample clock.
`timescale 1ns/1ns
module rfsme_source_model
    import rfsme_pkg::*;
(
    input wire logic mclk_i, // Sample clock
    output logic [SAMPLE_W-1:0] sample_o, // Sample word
    output logic valid_o // New-sample strobe
);
    logic [SAMPLE_W-1:0] last = '0;

    // Idle bus until the first word
    initial
    begin
        sample_o = '0;
        valid_o = 1'b0;
    end

    // One word per cycle; strobe stays high across back-to-back words
    task automatic send(input logic [SAMPLE_W-1:0] word);
        last = word;
        sample_o = word;
        valid_o = 1'b1;
        @(negedge mclk_i);
    endtask : send

    // Unmodulated carrier level
    task automatic carrier();
        send({CARRIER_STEPS, 5'h00});
    endtask : carrier

    // Word inverted when idle, so a stale value cannot pass for a sample
    task automatic idle();
        valid_o = 1'b0;
        sample_o = ~last;
        @(negedge mclk_i);
    endtask : idle
endmodule : rfsme_source_model

// ===== rfsme_encoder_tb.sv
// Self-checking bench for the step modulation encoder.
// Assumes samples change on falling edges; outputs are judged half a cycle after each take.
`timescale 1ns/1ns
module rfsme_encoder_tb
    import rfsme_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [SAMPLE_W-1:0] sample;
    logic sample_valid;
    logic [COARSE_AMPS-1:0] coarse_en;
    logic [FINE_W-1:0] fine_en;
    logic [COUNT_W-1:0] coarse_count;
    logic [AMPL_W-1:0] amplitude;
    int fail_count = 0;
    int check_count = 0;

    // 100 MHz sample clock
    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end

    rfsme_encoder u_dut (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sample_i(sample),
        .sample_valid_i(sample_valid),
        .coarse_en_o(coarse_en),
        .fine_en_o(fine_en),
        .coarse_count_o(coarse_count),
        .amplitude_o(amplitude)
    );
    rfsme_source_model src (
        .mclk_i(mclk_i),
        .sample_o(sample),
        .valid_o(sample_valid)
    );

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // Expected enables worked out from the word alone
    task automatic expect_word(input logic [SAMPLE_W-1:0] w);
        logic [COUNT_W-1:0] n;
        n = (w[COARSE_MSB_POS:COARSE_LSB_POS] > MAX_STEPS) ? MAX_STEPS : w[COARSE_MSB_POS:COARSE_LSB_POS];
        check("coarse_en", 128'(coarse_en), (128'h1 << n) - 128'h1);
        check("fine_en", 128'(fine_en), 128'(w[4:0]));
        check("coarse_count", 128'(coarse_count), 128'(n));
        check("amplitude", 128'(amplitude), 128'({n, w[4:0]}));
    endtask : expect_word

    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // Carrier, rollover, peak and zero back to back
    task automatic t_ramp();
        src.carrier();
        expect_word(12'h5e0);
        src.send(12'h5ff);
        expect_word(12'h5ff);
        src.send(12'h600);
        expect_word(12'h600);
        src.send(12'hbc0);
        check("peak_count", 128'(coarse_count), 128'(PEAK_STEPS));
        expect_word(12'hbc0);
        src.send(12'h000);
        expect_word(12'h000);
        src.idle();
    endtask : t_ramp

    // Each fine bit alone over a mid-range coarse value
    task automatic t_fine();
        for (int i = 0; i < 5; i++)
        begin
            src.send(12'h7e0 | (12'h001 << i));
            expect_word(12'h7e0 | (12'h001 << i));
        end
        src.idle();
    endtask : t_fine

    // Coarse values around and above the amplifier count
    task automatic t_sat();
        for (int c = 122; c < 128; c++)
        begin
            src.send({7'(c), 5'h1f});
            expect_word({7'(c), 5'h1f});
        end
        src.idle();
    endtask : t_sat

    // Outputs hold without a strobe and while the clock enable is low
    task automatic t_hold();
        src.send(12'h321);
        src.idle();
        expect_word(12'h321);
        ce_i = 1'b0;
        src.send(12'habc);
        expect_word(12'h321);
        ce_i = 1'b1;
        src.idle();
    endtask : t_hold

    // Reset in mid-run clears everything, then sampling resumes
    task automatic t_midreset();
        src.send(12'h7ff);
        src.idle();
        rst_i = 1'b1;
        @(negedge mclk_i);
        expect_word(12'h000);
        rst_i = 1'b0;
        @(negedge mclk_i);
        src.send(12'h5e1);
        expect_word(12'h5e1);
    endtask : t_midreset

    initial
    begin
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_i = 1'b0;
        @(negedge mclk_i);
        expect_word(12'h000);
        t_ramp();
        t_fine();
        t_sat();
        t_hold();
        t_midreset();
        give_verdict();
    end

    // Watchdog: the tests need well under a thousand cycles
    initial
    begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule : rfsme_encoder_tb
